// [src/phy_link_defines.svh]
`ifndef PHY_LINK_DEFINES_SVH
`define PHY_LINK_DEFINES_SVH

// Request type codes, bits 1..3 of a request
`define REQ_IMMEDIATE     3'h0
`define REQ_ISOCHRONOUS   3'h1
`define REQ_PRIORITY      3'h2
`define REQ_FAIR          3'h3
`define REQ_READ          3'h4
`define REQ_WRITE         3'h5
`define REQ_ACCEL         3'h6

// Request stream lengths in bits, start and stop included
`define LEN_BUS_LONG      5'h08
`define LEN_READ          5'h09
`define LEN_WRITE         5'h11
`define LEN_ACCEL         5'h06

// Speed field code for the 400 rate
`define SPEED_RATE_400    3'h4

// Control pair codes driven by the device
`define CTL_IDLE          2'h0
`define CTL_STATUS        2'h1
`define CTL_RECEIVE       2'h2
`define CTL_GRANT         2'h3

// Final status counter values, one less than transfer length in cycles
`define STAT_CYC_SHORT    3'h1
`define STAT_CYC_LONG     3'h7

// Register holding acceleration enable, and its bit
`define ACCEL_REG_ADDR    4'h5
`define ACCEL_EN_BIT      1
// Register holding the node address, sent after self identification unless a read is already pending
`define NODE_ID_REG_ADDR  4'h0

// Number of device registers
`define NUM_REGS          16

`endif

// [src/phy_link_pkg.sv]
package phy_link_pkg;

    typedef enum logic [2:0] {
        BUS_IMMEDIATE   = 3'h0,
        BUS_ISOCHRONOUS = 3'h1,
        BUS_PRIORITY    = 3'h2,
        BUS_FAIR        = 3'h3
    } bus_kind_t;

    typedef struct packed {
        logic      valid;
        bus_kind_t kind;
        logic      speed_ok;
        logic      rate_400;
    } bus_req_t;

    typedef struct packed {
        logic arb_reset_gap;
        logic subaction_gap;
        logic bus_reset;
        logic interrupt;
    } status_flags_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SEND  = 3'b010,
        ST_GAP   = 3'b100
    } stat_state_t;

endpackage

// [src/request_decoder.sv]
`timescale 1ns/10ps
`include "phy_link_defines.svh"

// Shifts in the serial request stream, reports each complete request.
module request_decoder
    import phy_link_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Serial request line
    input  wire logic        link_request_line,
    // Decoded request, one-cycle pulse
    output logic             done,
    output logic [2:0]       req_type,
    output logic [15:0]      payload,
    output logic [4:0]       length
);

    typedef struct packed {
        logic        busy;
        logic [4:0]  count;
        logic [16:0] shift;
        logic        done;
        logic [2:0]  req_type;
        logic [15:0] payload;
        logic [4:0]  length;
    } dec_state_t;

    dec_state_t state_reg;
    dec_state_t state_next;

    logic [4:0]  total_bits;
    logic [16:0] shifted;

    always_comb begin
        state_next      = state_reg;
        state_next.done = 1'b0;
        shifted         = {state_reg.shift[15:0], link_request_line};
        total_bits      = 5'h00;
        if (!state_reg.busy) begin
            if (link_request_line) begin
                state_next.busy  = 1'b1;
                state_next.count = 5'h01;
                state_next.shift = 17'h00001;
            end
        end else begin
            state_next.shift = shifted;
            state_next.count = state_reg.count + 5'h01;
            if (state_reg.count >= 5'h04) begin
                unique case (state_reg.shift[state_reg.count - 5'h04 +: 3])
                    `REQ_READ:  total_bits = `LEN_READ;
                    `REQ_WRITE: total_bits = `LEN_WRITE;
                    `REQ_ACCEL: total_bits = `LEN_ACCEL;
                    default:    total_bits = `LEN_BUS_LONG;
                endcase
            end
            // Bus requests always run the full 8 bits
            if (state_reg.count + 5'h01 == total_bits) begin
                state_next.busy     = 1'b0;
                state_next.done     = 1'b1;
                state_next.length   = total_bits;
                state_next.req_type = shifted[total_bits - 5'h02 -: 3];
                state_next.payload  = 16'(shifted >> 1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign done     = state_reg.done;
    assign req_type = state_reg.req_type;
    assign payload  = state_reg.payload;
    assign length   = state_reg.length;

endmodule

// [src/phy_link_request_status.sv]
`timescale 1ns/10ps
`include "phy_link_defines.svh"
// Functional notes
// - Requests start with 1, stop with 0, MSB first; line idles low.
// - Bits 1-3 give request type, immediate through acceleration control.
// - Everything is driven and sampled on the interface clock rising edge.
// - Speed 100 is rate 400; 000 and 010 also valid, others invalid, processed but sent as null.
// - Register read request is 9 bits with 4-bit address.
// - Register write request is 17 bits, address then 8 data bits.
// - Acceleration request is 6 bits with one enable bit.
// - Receive cancels pending fair/priority; receive during shifting ignores it.
// - Isochronous request stays pending until the bus is won.
// - Immediate request during reception is granted at packet end.
// - One bus request at a time; bus reset clears pending requests.
// - Write data loads at stream end; register requests accepted anytime.
// - Read contents go out by status transfer, retried if interrupted.
// - Further reads ignored while one pending; bus reset keeps it.
// - Acceleration features active only while the enable bit is set.
// - Acceleration request acts at once; reset or iso re-enables.
// - Status starts only when idle, code 01, two bits per clock.
// - Status lasts 2 cycles for flags alone, 8 with register.
// - Flags delivered when sent; register only after all bits sent.
// - At least one idle cycle between status transfers.
// - After self identification the node address register is sent; this design skips it if a read is already pending.
// - Status ends with idle, or grant if a bus reset is pending.
// - Status order: gaps, bus reset, interrupt, address, contents.
module phy_link_request_status
    import phy_link_pkg::*;
#(
    parameter int NUM_REGS = `NUM_REGS
)(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // Link request line
    input  wire logic        link_request_line,
    // Core-side events
    input  wire logic        receive_active,
    input  wire logic        bus_won,
    input  wire logic        bus_lost,
    input  wire logic        bus_reset_event,
    input  wire logic        self_id_done,
    input  wire status_flags_t flag_events,
    input  wire logic [7:0]  reg_read_data,
    // Control pair and low data lines toward the link
    output logic [1:0]       interface_control_pair,
    output logic [1:0]       data_low,
    output logic             data_oe,
    // Requests and register control to the core
    output bus_req_t         pending_bus_request,
    output logic             immediate_grant,
    output logic             acceleration_active,
    output logic [3:0]       reg_write_addr,
    output logic [7:0]       reg_write_data,
    output logic             reg_write_strobe,
    output logic [3:0]       reg_read_addr
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // Request decoding

    logic        req_done;
    logic [2:0]  req_type;
    logic [15:0] req_payload;
    logic [4:0]  req_length;

    request_decoder u_decoder (
        .clk_sys           (clk_sys),
        .rst_n             (rst_n),
        .link_request_line (link_request_line),
        .done              (req_done),
        .req_type          (req_type),
        .payload           (req_payload),
        .length            (req_length)
    );

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        bus_req_t      bus_req;
        logic          rx_seen;
        logic          in_req;
        logic          recv_prev;
        logic          imm_grant;
        logic          accel_bit;
        logic          accel_on;
        logic [7:0]    accel_reg;
        logic          read_pend;
        logic [3:0]    read_addr;
        logic          wr_strobe;
        logic [3:0]    wr_addr;
        logic [7:0]    wr_data;
        status_flags_t flags_pend;
        logic          reset_pend;
        stat_state_t   st;
        logic [2:0]    st_cnt;
        logic          st_long;
        logic [15:0]   st_word;
        logic [1:0]    ctl;
        logic [1:0]    dat;
        logic          oe;
    } top_state_t;

    top_state_t s_reg;
    top_state_t s_next;

    logic [2:0] speed;
    logic       new_bus;
    logic       flags_any;

    always_comb begin
        s_next           = s_reg;
        s_next.wr_strobe = 1'b0;
        s_next.imm_grant = 1'b0;
        s_next.recv_prev = receive_active;
        speed            = req_payload[2:0];
        new_bus          = req_done && !req_type[2];
        flags_any        = |s_reg.flags_pend;

        if (bus_reset_event) begin
            s_next.reset_pend = 1'b1;
        end

        // A receive inside the current stream voids a new fair/priority request
        if (receive_active) begin
            s_next.rx_seen = 1'b1;
        end
        if (req_done) begin
            s_next.in_req = 1'b0;
        end
        if ((!s_reg.in_req || req_done) && link_request_line) begin
            s_next.in_req  = 1'b1;
            s_next.rx_seen = receive_active;
        end

        // Bus request bookkeeping
        if (bus_won || bus_lost) begin
            s_next.bus_req.valid = 1'b0;
        end
        if (receive_active && s_reg.bus_req.valid
            && (s_reg.bus_req.kind == BUS_FAIR
                || s_reg.bus_req.kind == BUS_PRIORITY)) begin
            s_next.bus_req.valid = 1'b0;
        end
        if (bus_lost && s_reg.bus_req.kind == BUS_ISOCHRONOUS) begin
            s_next.bus_req.valid = s_reg.bus_req.valid;
        end
        if (new_bus && !s_reg.bus_req.valid
            && !((req_type == `REQ_FAIR || req_type == `REQ_PRIORITY)
                 && (s_reg.rx_seen || receive_active))) begin
            s_next.bus_req.valid    = 1'b1;
            s_next.bus_req.kind     = bus_kind_t'(req_type);
            s_next.bus_req.rate_400 = (speed == `SPEED_RATE_400);
            s_next.bus_req.speed_ok = (speed == 3'h0 || speed == 3'h2
                                       || speed == `SPEED_RATE_400);
            if (req_type == `REQ_ISOCHRONOUS) begin
                s_next.accel_on = s_reg.accel_bit;
            end
        end
        // Immediate request granted at end of reception
        if (s_reg.bus_req.valid && s_reg.bus_req.kind == BUS_IMMEDIATE
            && s_reg.recv_prev && !receive_active) begin
            s_next.imm_grant     = 1'b1;
            s_next.bus_req.valid = 1'b0;
        end
        if (bus_reset_event) begin
            s_next.bus_req.valid = 1'b0;
            s_next.accel_on      = s_reg.accel_bit;
        end

        if (req_done && req_type == `REQ_WRITE) begin
            s_next.wr_strobe = 1'b1;
            s_next.wr_addr   = req_payload[11:8];
            s_next.wr_data   = req_payload[7:0];
            if (req_payload[11:8] == `ACCEL_REG_ADDR) begin
                s_next.accel_reg = req_payload[7:0];
                s_next.accel_bit = req_payload[`ACCEL_EN_BIT];
                s_next.accel_on  = req_payload[`ACCEL_EN_BIT];
            end
        end
        if (req_done && req_type == `REQ_ACCEL) begin
            s_next.accel_on = req_payload[0];
        end
        if (req_done && req_type == `REQ_READ && !s_reg.read_pend) begin
            s_next.read_pend = 1'b1;
            s_next.read_addr = req_payload[3:0];
        end
        if (self_id_done && !s_reg.read_pend) begin
            s_next.read_pend = 1'b1;
            s_next.read_addr = `NODE_ID_REG_ADDR;
        end

        // Status transfer engine
        unique case (s_reg.st)
            ST_IDLE: begin
                s_next.ctl = `CTL_IDLE;
                s_next.oe  = 1'b1;
                s_next.dat = 2'h0;
                if (!receive_active && (flags_any || s_reg.read_pend)
                    && s_reg.ctl == `CTL_IDLE) begin
                    s_next.st      = ST_SEND;
                    s_next.st_long = s_reg.read_pend;
                    s_next.st_word = {s_reg.flags_pend, s_reg.read_addr,
                                      reg_read_data};
                    s_next.st_cnt  = 3'h0;
                    s_next.ctl     = `CTL_STATUS;
                    s_next.dat     = s_reg.flags_pend[3:2];
                    s_next.flags_pend.arb_reset_gap = 1'b0;
                    s_next.flags_pend.subaction_gap = 1'b0;
                end
            end
            ST_SEND: begin
                if (receive_active) begin
                    // Interrupted; unsent items remain pending for retry
                    s_next.st  = ST_GAP;
                    s_next.ctl = `CTL_RECEIVE;
                end else if (s_reg.st_cnt == (s_reg.st_long ? `STAT_CYC_LONG
                                              : `STAT_CYC_SHORT)) begin
                    s_next.st  = ST_GAP;
                    s_next.ctl = s_reg.reset_pend ? `CTL_GRANT
                                                  : `CTL_IDLE;
                    s_next.reset_pend = bus_reset_event;
                    s_next.dat = 2'h0;
                    if (s_reg.st_long) begin
                        s_next.read_pend = 1'b0;
                    end
                end else begin
                    s_next.st_cnt = s_reg.st_cnt + 3'h1;
                    s_next.dat = 2'(s_reg.st_word >> (12 - 2 * s_reg.st_cnt));
                    if (s_reg.st_cnt == 3'h0) begin
                        s_next.flags_pend.bus_reset = 1'b0;
                        s_next.flags_pend.interrupt = 1'b0;
                    end
                end
            end
            ST_GAP: begin
                // One idle cycle at least before the next transfer
                s_next.ctl = receive_active ? `CTL_RECEIVE : `CTL_IDLE;
                s_next.dat = 2'h0;
                if (!receive_active) begin
                    s_next.st = ST_IDLE;
                end
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase

        // New events set after delivery, so the set wins
        s_next.flags_pend = s_next.flags_pend | flag_events;
        s_next.accel_on   = s_next.accel_on && s_next.accel_bit;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg    <= '0;
            s_reg.st <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all registered

    assign interface_control_pair = s_reg.ctl;
    assign data_low               = s_reg.dat;
    assign data_oe                = s_reg.oe;
    assign pending_bus_request    = s_reg.bus_req;
    assign immediate_grant        = s_reg.imm_grant;
    assign acceleration_active    = s_reg.accel_on;
    assign reg_write_addr         = s_reg.wr_addr;
    assign reg_write_data         = s_reg.wr_data;
    assign reg_write_strobe       = s_reg.wr_strobe;
    assign reg_read_addr          = s_reg.read_addr;

endmodule

// [testbench/link_ctrl_model.sv]
`timescale 1ns/10ps

// Link side: one request stream at a time
module link_ctrl_model (
    // Clock and interface state
    input  wire logic        clk_sys,
    input  wire logic [1:0]  ctl,
    // Stream to send, left aligned
    input  wire logic        go,
    input  wire logic [16:0] bits,
    input  wire logic [4:0]  len,
    // Serial line and progress
    output logic             line,
    output logic             busy
);
    logic [16:0] sh_reg;
    logic [4:0]  cnt_reg;
    logic        run_reg;
    logic        idle_reg;

    initial begin
        line = 1'b0;
        busy = 1'b0;
        run_reg = 1'b0;
        idle_reg = 1'b0;
    end

    always @(posedge clk_sys) begin
        idle_reg <= (ctl == 2'h0);
        if (go && !busy) begin
            sh_reg  <= bits;
            cnt_reg <= len;
            busy    <= 1'b1;
        end else if (busy && cnt_reg == 5'h00) begin
            line    <= 1'b0;
            busy    <= 1'b0;
            run_reg <= 1'b0;
        // Fair and priority start only a clock past an idle interface
        end else if (busy && (run_reg || idle_reg ||
                              sh_reg[15:14] != 2'b01)) begin
            line    <= sh_reg[16];
            sh_reg  <= {sh_reg[15:0], 1'b0};
            cnt_reg <= cnt_reg - 5'h01;
            run_reg <= 1'b1;
        end
    end
endmodule

// [testbench/phy_link_request_status_chk.sv]
`timescale 1ns/10ps
`include "phy_link_defines.svh"

module phy_link_request_status_chk
    import phy_link_pkg::*;
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rstn,
    // Watched signals
    input wire logic       receive_active,
    input wire logic       bus_won,
    input wire logic       bus_reset_event,
    input wire logic [1:0] interface_control_pair,
    input wire logic       data_oe,
    input wire bus_req_t   pending_bus_request,
    input wire logic       immediate_grant
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    logic [1:0] ctl;
    logic       pv;
    assign ctl = interface_control_pair;
    assign pv  = pending_bus_request.valid;

    ////////////////////////////////////////////////////////////////////////
    property p_stat_gap;
        $past(ctl) == `CTL_STATUS && ctl != `CTL_STATUS |=> ctl != `CTL_STATUS;
    endproperty
    a_stat_gap: assert property (p_stat_gap)
        else $error("status transfers without idle between");
    property p_stat_idle;
        ctl == `CTL_STATUS && $past(ctl) != `CTL_STATUS
            |-> $past(ctl) == `CTL_IDLE;
    endproperty
    a_stat_idle: assert property (p_stat_idle)
        else $error("status started from a busy interface");
    // Receive cuts a transfer short, so it suspends the length check
    property p_stat_len;
        @(posedge clk_sys) disable iff (!rstn || receive_active)
        ctl == `CTL_STATUS && $past(ctl) != `CTL_STATUS |=>
            (ctl == `CTL_STATUS ##1 ctl != `CTL_STATUS) or
            (ctl == `CTL_STATUS [*7] ##1 ctl != `CTL_STATUS);
    endproperty
    a_stat_len: assert property (p_stat_len)
        else $error("status transfer length not 2 or 8");
    property p_stat_oe;
        ctl == `CTL_STATUS |-> data_oe;
    endproperty
    a_stat_oe: assert property (p_stat_oe)
        else $error("status sent with data lines undriven");
    property p_fair_cancel;
        receive_active && pv && pending_bus_request.kind inside
            {BUS_FAIR, BUS_PRIORITY} |-> ##[1:2] !pv;
    endproperty
    a_fair_cancel: assert property (p_fair_cancel)
        else $error("fair or priority request kept over receive");
    property p_iso_hold;
        pv && pending_bus_request.kind == BUS_ISOCHRONOUS && !bus_won &&
            !$past(bus_won) && !bus_reset_event && !$past(bus_reset_event)
            |=> pv;
    endproperty
    a_iso_hold: assert property (p_iso_hold)
        else $error("isochronous request dropped before won");
    property p_reset_clear;
        bus_reset_event |-> ##[1:2] !pv;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("bus request survived bus reset");
    property p_imm_grant;
        $fell(receive_active) && pv &&
            pending_bus_request.kind == BUS_IMMEDIATE |-> ##[0:2] immediate_grant;
    endproperty
    a_imm_grant: assert property (p_imm_grant)
        else $error("no grant after receive with immediate pending");

    c_long: cover property (ctl == `CTL_STATUS [*8]);
    c_grant: cover property ($fell(receive_active) ##[0:2] immediate_grant);
    c_reset: cover property (pv ##1 bus_reset_event ##2 !pv);
endmodule

bind phy_link_request_status phy_link_request_status_chk u_chk (
    .clk_sys, .rstn, .receive_active, .bus_won, .bus_reset_event,
    .interface_control_pair, .data_oe, .pending_bus_request, .immediate_grant
);

// [testbench/phy_link_request_status_test.sv]
`timescale 1ns/10ps
`include "phy_link_defines.svh"

module phy_link_request_status_test
    import phy_link_pkg::*;
;
    logic          clk_sys = 1'b0;
    logic          rstn = 1'b0;
    logic          receive_active = 1'b0;
    logic          bus_won = 1'b0;
    logic          bus_lost = 1'b0;
    logic          bus_reset_event = 1'b0;
    logic          self_id_done = 1'b0;
    status_flags_t flag_events = '0;
    logic [7:0]    reg_read_data;
    logic [1:0]    interface_control_pair;
    logic [1:0]    data_low;
    logic          data_oe;
    bus_req_t      pending_bus_request;
    logic          immediate_grant;
    logic          acceleration_active;
    logic [3:0]    reg_write_addr;
    logic [7:0]    reg_write_data;
    logic          reg_write_strobe;
    logic [3:0]    reg_read_addr;
    logic          link_request_line;
    logic          go = 1'b0;
    logic          busy;
    logic [16:0]   bits = '0;
    logic [4:0]    len = '0;
    logic [15:0]   w;
    int            n_errors = 0;
    int            tests_run = 0;

    always #2.5 clk_sys = ~clk_sys;
    // Stand-in register file: contents follow from the address
    assign reg_read_data = {reg_read_addr, ~reg_read_addr};

    phy_link_request_status uut (
        .clk_sys, .rstn, .link_request_line, .receive_active, .bus_won,
        .bus_lost, .bus_reset_event, .self_id_done, .flag_events,
        .reg_read_data, .interface_control_pair, .data_low, .data_oe,
        .pending_bus_request, .immediate_grant, .acceleration_active,
        .reg_write_addr, .reg_write_data, .reg_write_strobe, .reg_read_addr
    );
    link_ctrl_model link (
        .clk_sys, .ctl(interface_control_pair), .go, .bits, .len,
        .line(link_request_line), .busy
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic pulse(input int s);
        bus_won         <= (s == 0);
        bus_lost        <= (s == 1);
        bus_reset_event <= (s == 2);
        self_id_done    <= (s == 3);
        cyc(1);
        {bus_won, bus_lost, bus_reset_event, self_id_done} <= 4'h0;
        cyc(1);
    endtask
    task automatic send(input logic [16:0] b, input logic [4:0] n);
        int k;
        k = 0;
        bits <= b;
        len  <= n;
        go   <= 1'b1;
        cyc(2);
        go <= 1'b0;
        while (busy && k < 100) begin
            cyc(1);
            k++;
        end
        if (k >= 100) begin
            n_errors++;
            complete_run();
        end
    endtask
    task automatic get_status(input int n);
        int k;
        k = 0;
        while (interface_control_pair !== `CTL_STATUS && k < 200) begin
            cyc(1);
            k++;
        end
        check(16'(k < 200), 16'h0001);
        w = '0;
        for (int i = 0; i < n; i++) begin
            check(16'(interface_control_pair), 16'(`CTL_STATUS));
            w = {w[13:0], data_low};
            cyc(1);
        end
        k = (n == 4) ? `CTL_STATUS : `CTL_IDLE;
        check(16'(interface_control_pair), 16'(k));
    endtask
    function automatic logic [15:0] word(input logic [3:0] a);
        return {4'h0, a, a, ~a};
    endfunction
    function automatic logic [16:0] breq(input logic [2:0] t, logic [2:0] s);
        return {1'b1, t, s, 10'h000};
    endfunction
    task automatic bus_is(input logic v, bus_kind_t k, logic [1:0] sp);
        cyc(3);
        if (v) check(16'(pending_bus_request), 16'({v, k, sp}));
        else check(16'(pending_bus_request.valid), 16'h0000);
    endtask
    task automatic accel(input logic b, input logic exp);
        send({1'b1, `REQ_ACCEL, b, 12'h000}, `LEN_ACCEL);
        cyc(3);
        check(16'(acceleration_active), 16'(exp));
    endtask
    task automatic t_write(input logic [3:0] a, input logic [7:0] d);
        int k;
        k = 0;
        send({1'b1, `REQ_WRITE, a, d, 1'b0}, `LEN_WRITE);
        while (reg_write_strobe !== 1'b1 && k < 8) begin
            cyc(1);
            k++;
        end
        check({reg_write_addr, reg_write_data, 4'(k < 8)}, {a, d, 4'h1});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_status();
        int k;
        send({1'b1, `REQ_READ, 4'h6, 9'h000}, `LEN_READ);
        // Receive holds the owed read back while a second one arrives
        receive_active <= 1'b1;
        send({1'b1, `REQ_READ, 4'h9, 9'h000}, `LEN_READ);
        receive_active <= 1'b0;
        get_status(8);
        check(w, word(4'h6));
        k = 0;
        repeat (40) begin
            cyc(1);
            if (interface_control_pair === `CTL_STATUS) k++;
        end
        check(16'(k), 16'h0000);
        send({1'b1, `REQ_READ, 4'hA, 9'h000}, `LEN_READ);
        get_status(4);
        receive_active <= 1'b1;
        cyc(4);
        receive_active <= 1'b0;
        get_status(8);
        check(w, word(4'hA));
        flag_events <= 4'hC;
        cyc(1);
        flag_events <= 4'h0;
        get_status(2);
        check(w, 16'h000C);
        pulse(3);
        get_status(8);
        check(w, word(`NODE_ID_REG_ADDR));
    endtask
    task automatic t_accel();
        t_write(`ACCEL_REG_ADDR, 8'h01 << `ACCEL_EN_BIT);
        accel(1'b1, 1'b1);
        accel(1'b0, 1'b0);
        pulse(2);
        check(16'(acceleration_active), 16'h0001);
        t_write(`ACCEL_REG_ADDR, 8'h00);
        accel(1'b1, 1'b0);
        t_write(`ACCEL_REG_ADDR, 8'h01 << `ACCEL_EN_BIT);
        accel(1'b0, 1'b0);
    endtask
    task automatic t_bus();
        send(breq(`REQ_FAIR, `SPEED_RATE_400), `LEN_BUS_LONG);
        bus_is(1'b1, BUS_FAIR, 2'b11);
        send(breq(`REQ_ISOCHRONOUS, 3'h0), `LEN_BUS_LONG);
        bus_is(1'b1, BUS_FAIR, 2'b11);
        pulse(1);
        bus_is(1'b0, BUS_FAIR, 2'b00);
        send(breq(`REQ_PRIORITY, 3'h3), `LEN_BUS_LONG);
        bus_is(1'b1, BUS_PRIORITY, 2'b00);
        receive_active <= 1'b1;
        cyc(3);
        receive_active <= 1'b0;
        bus_is(1'b0, BUS_FAIR, 2'b00);
        fork
            send(breq(`REQ_FAIR, 3'h0), `LEN_BUS_LONG);
            begin
                cyc(4);
                receive_active <= 1'b1;
                cyc(3);
                receive_active <= 1'b0;
            end
        join
        bus_is(1'b0, BUS_FAIR, 2'b00);
        send(breq(`REQ_ISOCHRONOUS, 3'h2), `LEN_BUS_LONG);
        bus_is(1'b1, BUS_ISOCHRONOUS, 2'b10);
        check(16'(acceleration_active), 16'h0001);
        pulse(1);
        bus_is(1'b1, BUS_ISOCHRONOUS, 2'b10);
        pulse(0);
        bus_is(1'b0, BUS_FAIR, 2'b00);
        // Immediate request during reception
        receive_active <= 1'b1;
        send(breq(`REQ_IMMEDIATE, 3'h4), `LEN_BUS_LONG);
        cyc(3);
        receive_active <= 1'b0;
        repeat (4) begin
            cyc(1);
            w[0] = w[0] | (immediate_grant === 1'b1);
        end
        check(16'(w[0]), 16'h0001);
        pulse(0);
        send(breq(`REQ_FAIR, 3'h0), `LEN_BUS_LONG);
        bus_is(1'b1, BUS_FAIR, 2'b10);
        pulse(2);
        bus_is(1'b0, BUS_FAIR, 2'b00);
    endtask

    initial begin
        cyc(10);
        rstn <= 1'b1;
        cyc(4);
        t_write(4'h3, 8'hA5);
        t_status();
        t_accel();
        w = '0;
        t_bus();
        cyc(5);
        complete_run();
    end
endmodule
